// File: hw/irpe_map.svh
// Offsets, field positions, reset values and timing counts of the infrared pulse endec
`ifndef IRPE_MAP_SVH
`define IRPE_MAP_SVH

// Register byte addresses
`define IRPE_ADDR_CTRL 8'h00
`define IRPE_ADDR_STATUS 8'h04
`define IRPE_ADDR_WORD 8'h08

// Control word and control register layout
`define IRPE_RATE_LSB 0
`define IRPE_RATE_MSB 3
`define IRPE_WIDTH_BIT 4
`define IRPE_RATE_DEFAULT 4'h6
`define IRPE_WIDTH_DEFAULT 1'b0
`define IRPE_RATE_LAST 4'hc

// Status register layout
`define IRPE_ST_MODE_BIT 0
`define IRPE_ST_PEND_BIT 1
`define IRPE_ST_TXBUSY_BIT 2
`define IRPE_ST_RXBUSY_BIT 3

// Reference clock synthesis: system 50 MHz, reference 3.6864 MHz (both in units of 100 Hz)
`define IRPE_SYS_HZ100 19'd500000
`define IRPE_REF_HZ100 19'd36864

// Fixed pulse: 1627 ns, as whole reference periods rounded up
`define IRPE_FIXED_PULSE_NS 1627
`define IRPE_FIXED_PULSE_REF ((`IRPE_FIXED_PULSE_NS * 36864 + 9999999) / 10000000)
// Three sixteenths of a bit
`define IRPE_PULSE_16THS 3
// Sixteenth ticks per bit
`define IRPE_TICKS_PER_BIT 16
// Start bit is checked at its middle
`define IRPE_START_MID 7

`endif

// File: hw/irpe_pkg.sv
// Types shared by the infrared pulse endec modules
package irpe_pkg;

    // Rate and pulse width currently in force
    typedef struct packed {
        logic width_316;
        logic [3:0] rate;
    } irpe_cfg_t;

    // Receiver for the control word character
    typedef enum logic [1:0] {
        IRPE_RX_IDLE,
        IRPE_RX_START,
        IRPE_RX_DATA,
        IRPE_RX_STOP
    } irpe_uart_st_t;

    // Reference periods per sixteenth of a bit for each of the 13 rates
    function automatic logic [7:0] irpe_div16(input logic [3:0] rate);
        logic [7:0] div;
        div = 8'h18;
        unique case (rate)
            4'h0: div = 8'h02; // 115200
            4'h1: div = 8'h04; // 57600
            4'h2: div = 8'h06; // 38400
            4'h3: div = 8'h08; // 28800
            4'h4: div = 8'h0c; // 19200
            4'h5: div = 8'h10; // 14400
            4'h6: div = 8'h18; // 9600
            4'h7: div = 8'h20; // 7200
            4'h8: div = 8'h30; // 4800
            4'h9: div = 8'h40; // 3600
            4'ha: div = 8'h60; // 2400
            4'hb: div = 8'h80; // 1800
            4'hc: div = 8'hc0; // 1200
            default: div = 8'h18;
        endcase
        return div;
    endfunction

endpackage

// File: hw/irpe_tx_shaper.sv
// Transmit shaper: turns each low host bit into one short infrared pulse
`timescale 1ns/1ns
`default_nettype none
`include "irpe_map.svh"

module irpe_tx_shaper import irpe_pkg::*; (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_en,
    input wire logic i_ref_tick,
    input wire logic i_tick16,
    input wire logic i_tx_low,
    input wire logic i_width316,
    output logic o_ir_tx,
    output logic o_busy
);

    typedef struct packed {
        logic arm;
        logic active;
        logic [3:0] phase;
        logic pulse;
        logic [3:0] plen;
    } irpe_tx_state_t;

    irpe_tx_state_t s_q;
    irpe_tx_state_t s_d;

    // Bit phase tracking and pulse timing
    always_comb begin
        s_d = s_q;
        if (!i_en) begin
            s_d = '0;
        end else begin
            // End the running pulse
            if (s_q.pulse) begin
                if (i_width316 && i_tick16) begin
                    s_d.plen = 4'(s_q.plen + 4'h1);
                    if (s_q.plen == 4'(`IRPE_PULSE_16THS - 1)) begin
                        s_d.pulse = 1'b0;
                    end
                end else if (!i_width316 && i_ref_tick) begin
                    s_d.plen = 4'(s_q.plen + 4'h1);
                    if (s_q.plen == 4'(`IRPE_FIXED_PULSE_REF - 1)) begin
                        s_d.pulse = 1'b0;
                    end
                end
            end
            // Fixed pulse waits for a reference tick so that it spans whole periods
            if (s_q.arm) begin
                if (!i_tx_low) begin
                    s_d.arm = 1'b0;
                end else if (i_ref_tick) begin
                    s_d.arm = 1'b0;
                    s_d.pulse = 1'b1;
                    s_d.plen = 4'h0;
                end
            end
            // Start a pulse at the head of each low bit
            if (!s_q.active) begin
                if (i_tx_low) begin
                    s_d.active = 1'b1;
                    s_d.phase = 4'h0;
                    s_d.pulse = i_width316;
                    s_d.arm = !i_width316;
                    s_d.plen = 4'h0;
                end
            end else if (i_tick16) begin
                s_d.phase = 4'(s_q.phase + 4'h1);
                if (s_q.phase == 4'(`IRPE_TICKS_PER_BIT - 1)) begin
                    if (i_tx_low) begin
                        s_d.pulse = i_width316;
                        s_d.arm = !i_width316;
                        s_d.plen = 4'h0;
                    end else begin
                        s_d.active = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_ir_tx = s_q.pulse;
    assign o_busy = s_q.active;

endmodule // irpe_tx_shaper
`default_nettype wire

// File: hw/irpe_rx_stretch.sv
// Receive stretcher: widens each infrared pulse to one full low bit
`timescale 1ns/1ns
`default_nettype none
`include "irpe_map.svh"

module irpe_rx_stretch import irpe_pkg::*; (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_en,
    input wire logic i_tick16,
    input wire logic i_rx_low,
    output logic o_host_rx,
    output logic o_busy
);

    typedef struct packed {
        logic prev_low;
        logic active;
        logic [3:0] cnt;
        logic out;
    } irpe_rx_state_t;

    irpe_rx_state_t s_q;
    irpe_rx_state_t s_d;

    // A new pulse restarts the bit; otherwise count sixteen ticks
    always_comb begin
        s_d = s_q;
        s_d.prev_low = i_rx_low;
        if (!i_en) begin
            s_d.active = 1'b0;
            s_d.cnt = 4'h0;
            s_d.out = 1'b1;
        end else if (i_rx_low && !s_q.prev_low) begin
            s_d.active = 1'b1;
            s_d.cnt = 4'h0;
            s_d.out = 1'b0;
        end else if (s_q.active && i_tick16) begin
            s_d.cnt = 4'(s_q.cnt + 4'h1);
            if (s_q.cnt == 4'(`IRPE_TICKS_PER_BIT - 1)) begin
                s_d.active = 1'b0;
                s_d.out = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '{prev_low: 1'b0, active: 1'b0, cnt: 4'h0, out: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_host_rx = s_q.out;
    assign o_busy = s_q.active;

endmodule // irpe_rx_stretch
`default_nettype wire

// File: hw/irpe_top.sv
// Infrared pulse endec: reference clock, baud generator, control word, APB registers
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "irpe_map.svh"

module irpe_top import irpe_pkg::*; (
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic I_PROGRAM_MODE_SELECT,
    input wire logic I_HOST_TX_IN,
    input wire logic I_IR_RX_IN,
    output logic O_IR_TX_OUT,
    output logic O_HOST_RX_OUT,
    output logic O_TRANSCEIVER_SHUTDOWN_OUT,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic tx_s1;
        logic tx_s2;
        logic rx_s1;
        logic rx_s2;
        logic md_s1;
        logic md_s2;
        logic md_prev;
        logic [18:0] nco;
        logic ref_tick;
        logic [7:0] bcnt;
        logic tick16;
        irpe_cfg_t cfg;
        logic [7:0] pend;
        logic pend_valid;
        irpe_uart_st_t ust;
        logic [3:0] ucnt;
        logic [2:0] ubits;
        logic [7:0] ushift;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } irpe_top_state_t;

    irpe_top_state_t s_q;
    irpe_top_state_t s_d;

    logic tx_busy;
    logic rx_busy;
    logic data_mode;
    logic apb_access;
    logic apb_done;
    logic addr_ok;
    logic [7:0] div16;

    // Synchronised mode select: low is data mode
    assign data_mode = !s_q.md_s2;
    assign div16 = irpe_div16(s_q.cfg.rate);
    assign apb_access = I_PSEL && I_PENABLE;
    assign apb_done = apb_access && s_q.pready;
    assign addr_ok = (I_PADDR == `IRPE_ADDR_CTRL) || (I_PADDR == `IRPE_ADDR_STATUS) ||
                     (I_PADDR == `IRPE_ADDR_WORD);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        s_d = s_q;

        // Two-stage synchronisers for the pins
        s_d.tx_s1 = I_HOST_TX_IN;
        s_d.tx_s2 = s_q.tx_s1;
        s_d.rx_s1 = I_IR_RX_IN;
        s_d.rx_s2 = s_q.rx_s1;
        s_d.md_s1 = I_PROGRAM_MODE_SELECT;
        s_d.md_s2 = s_q.md_s1;
        s_d.md_prev = s_q.md_s2;

        // Fractional divider makes the 3.6864 MHz reference tick
        if (s_q.nco >= 19'(`IRPE_SYS_HZ100 - `IRPE_REF_HZ100)) begin
            s_d.nco = 19'(s_q.nco + `IRPE_REF_HZ100 - `IRPE_SYS_HZ100);
            s_d.ref_tick = 1'b1;
        end else begin
            s_d.nco = 19'(s_q.nco + `IRPE_REF_HZ100);
            s_d.ref_tick = 1'b0;
        end

        // Baud generator: one tick per sixteenth of a bit
        s_d.tick16 = 1'b0;
        if (s_q.ref_tick) begin
            if (s_q.bcnt >= 8'(div16 - 8'h01)) begin
                s_d.bcnt = 8'h00;
                s_d.tick16 = 1'b1;
            end else begin
                s_d.bcnt = 8'(s_q.bcnt + 8'h01);
            end
        end

        // Control word receiver, active only in programming mode
        if (!s_q.md_s2) begin
            s_d.ust = IRPE_RX_IDLE;
            s_d.ucnt = 4'h0;
        end else begin
            unique case (s_q.ust)
                IRPE_RX_IDLE: begin
                    if (!s_q.tx_s2) begin
                        s_d.ust = IRPE_RX_START;
                        s_d.ucnt = 4'h0;
                    end
                end
                IRPE_RX_START: begin
                    if (s_q.tick16) begin
                        s_d.ucnt = 4'(s_q.ucnt + 4'h1);
                        if (s_q.ucnt == 4'(`IRPE_START_MID)) begin
                            s_d.ucnt = 4'h0;
                            s_d.ubits = 3'h0;
                            s_d.ust = s_q.tx_s2 ? IRPE_RX_IDLE : IRPE_RX_DATA;
                        end
                    end
                end
                IRPE_RX_DATA: begin
                    if (s_q.tick16) begin
                        s_d.ucnt = 4'(s_q.ucnt + 4'h1);
                        if (s_q.ucnt == 4'(`IRPE_TICKS_PER_BIT - 1)) begin
                            s_d.ushift = {s_q.tx_s2, s_q.ushift[7:1]};
                            s_d.ubits = 3'(s_q.ubits + 3'h1);
                            if (s_q.ubits == 3'h7) begin
                                s_d.ust = IRPE_RX_STOP;
                            end
                        end
                    end
                end
                IRPE_RX_STOP: begin
                    if (s_q.tick16) begin
                        s_d.ucnt = 4'(s_q.ucnt + 4'h1);
                        if (s_q.ucnt == 4'(`IRPE_TICKS_PER_BIT - 1)) begin
                            s_d.ust = IRPE_RX_IDLE;
                            if (s_q.tx_s2) begin
                                s_d.pend = s_q.ushift;
                                s_d.pend_valid = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end

        // Stored word takes effect on the fall of mode select
        if (s_q.md_prev && !s_q.md_s2 && s_q.pend_valid) begin
            s_d.pend_valid = 1'b0;
            if (s_q.pend[`IRPE_RATE_MSB:`IRPE_RATE_LSB] <= `IRPE_RATE_LAST) begin
                s_d.cfg.rate = s_q.pend[`IRPE_RATE_MSB:`IRPE_RATE_LSB];
                s_d.cfg.width_316 = s_q.pend[`IRPE_WIDTH_BIT];
                s_d.bcnt = 8'h00;
            end
        end

        // APB slave: one wait state, then answer
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (apb_access && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !addr_ok;
            s_d.prdata = 32'h0;
            if (!I_PWRITE) begin
                unique case (I_PADDR)
                    `IRPE_ADDR_CTRL: s_d.prdata = {27'h0, s_q.cfg};
                    `IRPE_ADDR_STATUS: s_d.prdata = {28'h0, rx_busy, tx_busy,
                                                     s_q.pend_valid, s_q.md_s2};
                    `IRPE_ADDR_WORD: s_d.prdata = {24'h0, s_q.pend};
                    default: s_d.prdata = 32'h0;
                endcase
            end
        end

        // Software write to control sets rate and width directly
        if (apb_done && I_PWRITE && (I_PADDR == `IRPE_ADDR_CTRL)) begin
            if (I_PWDATA[`IRPE_RATE_MSB:`IRPE_RATE_LSB] <= `IRPE_RATE_LAST) begin
                s_d.cfg.rate = I_PWDATA[`IRPE_RATE_MSB:`IRPE_RATE_LSB];
                s_d.cfg.width_316 = I_PWDATA[`IRPE_WIDTH_BIT];
                s_d.bcnt = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset clears the state but presets the transmit and receive pin synchronisers high, halts the reference and loads 9600 bit/s, fixed width
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            s_q <= '0;
            s_q.tx_s1 <= 1'b1;
            s_q.tx_s2 <= 1'b1;
            s_q.rx_s1 <= 1'b1;
            s_q.rx_s2 <= 1'b1;
            s_q.ust <= IRPE_RX_IDLE;
            s_q.cfg.rate <= `IRPE_RATE_DEFAULT;
            s_q.cfg.width_316 <= `IRPE_WIDTH_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse shaping paths

    // Transmit path, silent in programming mode
    irpe_tx_shaper u_tx (
        .i_clk(I_REF_CLK),
        .i_srst(I_SRST),
        .i_en(data_mode),
        .i_ref_tick(s_q.ref_tick),
        .i_tick16(s_q.tick16),
        .i_tx_low(!s_q.tx_s2),
        .i_width316(s_q.cfg.width_316),
        .o_ir_tx(O_IR_TX_OUT),
        .o_busy(tx_busy)
    );

    // Receive path, idle high in programming mode
    irpe_rx_stretch u_rx (
        .i_clk(I_REF_CLK),
        .i_srst(I_SRST),
        .i_en(data_mode),
        .i_tick16(s_q.tick16),
        .i_rx_low(!s_q.rx_s2),
        .o_host_rx(O_HOST_RX_OUT),
        .o_busy(rx_busy)
    );

    // Outputs
    assign O_TRANSCEIVER_SHUTDOWN_OUT = !I_SRST;
    assign O_PREADY = s_q.pready;
    assign O_PSLVERR = s_q.pslverr;
    assign O_PRDATA = s_q.prdata;

endmodule // irpe_top
`default_nettype wire

// File: tb/irpe_top_monitor.sv
// Port checker for the infrared pulse endec
`timescale 1ns/1ns
`default_nettype none

module irpe_monitor (
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic I_PROGRAM_MODE_SELECT,
    input wire logic I_HOST_TX_IN,
    input wire logic I_IR_RX_IN,
    input wire logic O_IR_TX_OUT,
    input wire logic O_HOST_RX_OUT,
    input wire logic O_TRANSCEIVER_SHUTDOWN_OUT,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR
);
    // One clock domain, one reset
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SRST);

    ////////////////////////////////////////////////////////////////////////////
    // Reset and shutdown
    chk_shutdown_level: assert property (O_TRANSCEIVER_SHUTDOWN_OUT)
        else $error("shutdown low outside reset");
    chk_reset_outputs: assert property ($fell(I_SRST) |-> !O_IR_TX_OUT && O_HOST_RX_OUT
        && !O_PREADY && O_PRDATA == 32'h0 && !$past(O_TRANSCEIVER_SHUTDOWN_OUT))
        else $error("outputs not at reset values");

    ////////////////////////////////////////////////////////////////////////////
    // Register bus answer
    chk_apb_answer: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("access phase not answered");
    chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");

    ////////////////////////////////////////////////////////////////////////////
    // Link side
    chk_prog_tx_quiet: assert property (I_PROGRAM_MODE_SELECT [*6] |-> !O_IR_TX_OUT)
        else $error("infrared pulse in programming mode");
    chk_prog_rx_idle: assert property (I_PROGRAM_MODE_SELECT [*6] |-> O_HOST_RX_OUT)
        else $error("host receive active in programming mode");
    chk_tx_cause: assert property ($rose(O_IR_TX_OUT) |-> !$past(I_HOST_TX_IN, 3))
        else $error("pulse without low host bit");
    chk_rx_cause: assert property ($fell(O_HOST_RX_OUT) |-> !$past(I_IR_RX_IN, 3))
        else $error("stretched bit without infrared pulse");
endmodule // irpe_monitor

bind irpe_top irpe_monitor u_mon (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST),
    .I_PROGRAM_MODE_SELECT(I_PROGRAM_MODE_SELECT), .I_HOST_TX_IN(I_HOST_TX_IN),
    .I_IR_RX_IN(I_IR_RX_IN), .O_IR_TX_OUT(O_IR_TX_OUT), .O_HOST_RX_OUT(O_HOST_RX_OUT),
    .O_TRANSCEIVER_SHUTDOWN_OUT(O_TRANSCEIVER_SHUTDOWN_OUT), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR));
`default_nettype wire

// File: tb/irpe_host_model.sv
// Host serial port model driving the transmit line
`timescale 1ns/1ns
`default_nettype none

module irpe_host_model (
    input wire logic i_clk,
    output logic o_host_tx
);
    // Line idles high
    initial o_host_tx = 1'b1;

    // Low level for n clocks, then idle again
    task automatic drive_low(input int n);
        @(posedge i_clk);
        o_host_tx <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_host_tx <= 1'b1;
    endtask

    // One 8N1 character, low bit first, stop bit held a full bit
    task automatic send_byte(input logic [7:0] b, input int bit_clks);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_host_tx <= frame[i];
            repeat (bit_clks - 1) @(posedge i_clk);
        end
    endtask
endmodule // irpe_host_model
`default_nettype wire

// File: tb/test_infrared_pulse_endec.sv
// Self-checking bench for the infrared pulse endec
`timescale 1ns/1ns
`default_nettype none

module test_infrared_pulse_endec;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic err;} irpe_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic mode = 1'b0;
    logic ir_rx = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic host_tx, ir_tx, host_rx, shut, pready, pslverr, err;
    logic [31:0] prdata, rd;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    // Register rows: direction, address, write data, read data, error
    irpe_row_t rows [11] = '{'{0, 8'h00, 0, 32'h06, 0}, '{1, 8'h00, 32'h0d, 0, 0},
        '{0, 8'h00, 0, 32'h06, 0}, '{1, 8'h00, 32'h0c, 0, 0}, '{0, 8'h00, 0, 32'h0c, 0},
        '{0, 8'h0c, 0, 32'h0, 1}, '{1, 8'h10, 32'h1, 0, 1}, '{1, 8'h00, 32'h00, 0, 0},
        '{0, 8'h00, 0, 32'h00, 0}, '{0, 8'h04, 0, 32'h0, 0}, '{0, 8'h08, 0, 32'h0, 0}};

    // 50 MHz clock
    always #10 clk = ~clk;

    irpe_top dut (.I_REF_CLK(clk), .I_SRST(srst), .I_PROGRAM_MODE_SELECT(mode),
        .I_HOST_TX_IN(host_tx), .I_IR_RX_IN(ir_rx), .O_IR_TX_OUT(ir_tx),
        .O_HOST_RX_OUT(host_rx), .O_TRANSCEIVER_SHUTDOWN_OUT(shut), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
    irpe_host_model u_host (.i_clk(clk), .o_host_tx(host_tx));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; waits for ready, only the hang guard ends the wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Length in clocks of the next pulse on infrared transmit or host receive
    function automatic logic active(input logic rx);
        return rx ? !host_rx : ir_tx;
    endfunction
    task automatic meas(input logic rx, output int len);
        int w;
        w = 0;
        len = 0;
        while (active(rx) !== 1'b1 && w < 3000) begin
            @(negedge clk);
            w++;
        end
        while (active(rx) === 1'b1 && len < 3000) begin
            @(negedge clk);
            len++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            $display("MISMATCH t=%0t timeout", $time);
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        check({31'h0, shut}, 32'h0, "shutdown in reset");
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].wd);
            if (!rows[i].wr) check(rd, rows[i].rd, "register read");
            check({31'h0, err}, {31'h0, rows[i].err}, "bus error");
        end
        $display("test registers done");
        // Fixed pulse at 115200: six reference periods
        fork
            u_host.drive_low(400);
            meas(1'b0, n);
        join
        check(32'(n >= 80 && n <= 83), 32'h1, "fixed pulse");
        // 3/16 at 57600: second pulse is twelve reference periods
        apb(1'b1, 8'h00, 32'h11);
        fork
            u_host.drive_low(1700);
            begin
                meas(1'b0, n);
                meas(1'b0, n);
            end
        join
        check(32'(n >= 160 && n <= 166), 32'h1, "3/16 pulse");
        $display("test transmit done");
        // Receive pulse of 2 us stretched to one bit at 57600
        fork
            begin
                @(posedge clk);
                ir_rx <= 1'b0;
                repeat (100) @(posedge clk);
                ir_rx <= 1'b1;
            end
            meas(1'b1, n);
        join
        check(32'(n >= 810 && n <= 870), 32'h1, "stretched bit");
        $display("test receive done");
        // Control word at the current rate, applied only on mode fall
        mode <= 1'b1;
        repeat (10) @(posedge clk);
        u_host.send_byte(8'h02, 868);
        repeat (20) @(posedge clk);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h3, "status in programming mode");
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h02, "control word stored");
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h11, "word applied early");
        mode <= 1'b0;
        repeat (10) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h02, "word not applied");
        $display("test control word done");
        // Reset in mid-run, held one microsecond
        srst <= 1'b1;
        repeat (50) @(posedge clk);
        check({29'h0, shut, ir_tx, host_rx}, 32'h1, "outputs in reset");
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h06, "defaults after reset");
        $display("test reset done");
        end_of_test();
    end
endmodule // test_infrared_pulse_endec
`default_nettype wire
